// file: logic/vxa_bus_if.sv
`timescale 1ns/1ps

interface vxa_bus_if;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic        write;
	logic        read;
	logic        byte_sz;
	logic [15:0] rdata;
	logic        ack;

	modport device (
		input  addr,
		input  wdata,
		input  write,
		input  read,
		input  byte_sz,
		output rdata,
		output ack
	);

	modport host (
		output addr,
		output wdata,
		output write,
		output read,
		output byte_sz,
		input  rdata,
		input  ack
	);
endinterface

// file: logic/vxa_defs.svh
`ifndef VXA_DEFS_SVH
`define VXA_DEFS_SVH

// register-device region of the 16-bit space
`define VXA_REGION_TOP      2'b11
`define VXA_REGION_START    16'hC000
`define VXA_BLOCK_SHIFT     6
`define VXA_LA_DEFAULT      8'h18

// window of the 16-bit register region (C000 up) inside the master's 24-bit space
`define VXA_MAP_START       24'h1FC000
`define VXA_MAP_PAGE        10'h07F

// device register offsets within the 64-byte block
`define VXA_OFF_ID          6'h00
`define VXA_OFF_TYPE        6'h02
`define VXA_OFF_STATUS      6'h04
`define VXA_OFF_CONTROL     6'h04
`define VXA_OFF_COMMAND     6'h08
`define VXA_OFF_QUERY       6'h08
`define VXA_OFF_PARAM       6'h0A
`define VXA_OFF_DATA        6'h0C

// host command port offsets
`define VXA_H_ADDR          4'h0
`define VXA_H_WDATA         4'h1
`define VXA_H_CTRL          4'h2
`define VXA_H_STATUS        4'h3
`define VXA_H_RDATA         4'h4

// host control fields
`define VXA_CTRL_GO         0
`define VXA_CTRL_WRITE      1
`define VXA_CTRL_BYTE       2
`define VXA_CTRL_LOGICAL    3
`define VXA_CTRL_MAPPED     4

// host status fields
`define VXA_STAT_BUSY       0
`define VXA_STAT_DONE       1
`define VXA_STAT_NORESP     2
`define VXA_STAT_BADADDR    3

// cycles the host waits for an acknowledge
`define VXA_ACK_TIMEOUT     4'h8

`endif

// file: logic/vxa_device.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

`include "vxa_defs.svh"

module vxa_device (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	vxa_bus_if.device        bus,
	input  wire logic        i_la_load,
	input  wire logic [7:0]  i_la_value,
	input  wire logic [15:0] i_id_value,
	input  wire logic [15:0] i_type_value,
	input  wire logic [15:0] i_status_value,
	input  wire logic [15:0] i_query_value,
	input  wire logic [15:0] i_data_value,
	output logic [7:0]       o_logical_address_setting,
	output logic [15:0]      o_control,
	output logic [15:0]      o_command,
	output logic [15:0]      o_parameter,
	output logic             o_control_strobe,
	output logic             o_command_strobe,
	output logic             o_parameter_strobe,
	output logic             o_query_taken,
	output logic             o_data_taken
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	logic       hit;
	logic [5:0] off;
	logic       odd;
	logic       access;

	always_comb begin
		off    = {bus.addr[5:1], 1'b0};
		odd    = bus.addr[0];
		access = bus.write | bus.read;
		hit    = (bus.addr[15:14] == `VXA_REGION_TOP)
		       && (bus.addr[13:6] == o_logical_address_setting);
	end

	////////////////////////////////////////////////////////////////////////////
	// logical address setting

	logic [7:0] next_la;

	always_comb begin
		next_la = o_logical_address_setting;
		if (i_la_load) begin
			next_la = i_la_value;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_logical_address_setting <= `VXA_LA_DEFAULT;
		end else begin
			o_logical_address_setting <= next_la;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write registers

	logic [15:0] next_control;
	logic [15:0] next_command;
	logic [15:0] next_parameter;
	logic        next_control_strobe;
	logic        next_command_strobe;
	logic        next_parameter_strobe;
	logic        wr_hit;

	always_comb begin
		next_control          = o_control;
		next_command          = o_command;
		next_parameter        = o_parameter;
		next_control_strobe   = 1'b0;
		next_command_strobe   = 1'b0;
		next_parameter_strobe = 1'b0;
		wr_hit                = bus.write & hit;
		// offset plus base selects the register
		if (wr_hit) begin
			case (off)
				`VXA_OFF_CONTROL: begin
					next_control        = vxa_pkg::vxa_lane_merge(o_control, bus.wdata,
					                                             bus.byte_sz, odd);
					next_control_strobe = 1'b1;
				end
				`VXA_OFF_COMMAND: begin
					next_command        = vxa_pkg::vxa_lane_merge(o_command, bus.wdata,
					                                             bus.byte_sz, odd);
					next_command_strobe = 1'b1;
				end
				`VXA_OFF_PARAM: begin
					next_parameter        = vxa_pkg::vxa_lane_merge(o_parameter, bus.wdata,
					                                               bus.byte_sz, odd);
					next_parameter_strobe = 1'b1;
				end
				default: begin
					// unused offset, write dropped
					next_control_strobe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_control          <= 16'h0000;
			o_command          <= 16'h0000;
			o_parameter        <= 16'h0000;
			o_control_strobe   <= 1'b0;
			o_command_strobe   <= 1'b0;
			o_parameter_strobe <= 1'b0;
		end else begin
			o_control          <= next_control;
			o_command          <= next_command;
			o_parameter        <= next_parameter;
			o_control_strobe   <= next_control_strobe;
			o_command_strobe   <= next_command_strobe;
			o_parameter_strobe <= next_parameter_strobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read registers

	logic [15:0] next_rdata;
	logic        next_query_taken;
	logic        next_data_taken;
	logic [15:0] rd_word;

	always_comb begin
		next_rdata       = 16'h0000;
		next_query_taken = 1'b0;
		next_data_taken  = 1'b0;
		rd_word          = 16'h0000;
		if (bus.read && hit) begin
			case (off)
				`VXA_OFF_ID: begin
					rd_word = i_id_value;
				end
				`VXA_OFF_TYPE: begin
					rd_word = i_type_value;
				end
				`VXA_OFF_STATUS: begin
					rd_word = i_status_value;
				end
				`VXA_OFF_QUERY: begin
					rd_word          = i_query_value;
					next_query_taken = 1'b1;
				end
				`VXA_OFF_DATA: begin
					rd_word         = i_data_value;
					next_data_taken = 1'b1;
				end
				default: begin
					// unused offset reads zero
					rd_word = 16'h0000;
				end
			endcase
			next_rdata = vxa_pkg::vxa_lane_pick(rd_word, bus.byte_sz, odd);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			bus.rdata     <= 16'h0000;
			o_query_taken <= 1'b0;
			o_data_taken  <= 1'b0;
		end else begin
			bus.rdata     <= next_rdata;
			o_query_taken <= next_query_taken;
			o_data_taken  <= next_data_taken;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acknowledge

	logic next_ack;

	always_comb begin
		// every access in the block is acknowledged one cycle later
		next_ack = access & hit;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			bus.ack <= 1'b0;
		end else begin
			bus.ack <= next_ack;
		end
	end

endmodule

// file: logic/vxa_host.sv
`timescale 1ns/1ps

`include "vxa_defs.svh"

module vxa_host (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	vxa_bus_if.host          bus,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_write,
	input  wire logic        i_read,
	output logic [31:0]      o_rdata
);

	////////////////////////////////////////////////////////////////////////////
	// command registers and bus sequencer

	vxa_pkg::vxa_host_state_t state;
	vxa_pkg::vxa_host_state_t next_state;

	logic [23:0] target;
	logic [15:0] wdata;
	logic [4:0]  ctrl;
	logic [3:0]  status;
	logic [15:0] rdata;
	logic [3:0]  wait_cnt;
	logic [23:0] next_target;
	logic [15:0] next_wdata;
	logic [4:0]  next_ctrl;
	logic [3:0]  next_status;
	logic [15:0] next_rdata;
	logic [3:0]  next_wait_cnt;
	logic [31:0] next_o_rdata;
	logic [15:0] next_addr;
	logic [15:0] next_bus_wdata;
	logic        next_write;
	logic        next_read;
	logic        next_byte;
	logic [15:0] a16;
	logic        addr_ok;
	logic        go;

	always_comb begin
		next_state     = state;
		next_target    = target;
		next_wdata     = wdata;
		next_ctrl      = ctrl;
		next_status    = status;
		next_rdata     = rdata;
		next_wait_cnt  = wait_cnt;
		next_addr      = bus.addr;
		next_bus_wdata = bus.wdata;
		next_write     = 1'b0;
		next_read      = 1'b0;
		next_byte      = bus.byte_sz;
		next_o_rdata   = 32'h0000_0000;
		a16            = target[15:0];
		addr_ok        = 1'b1;
		go             = 1'b0;
		// address forms: logical+offset, mapped 24-bit, or raw 16-bit
		if (ctrl[`VXA_CTRL_LOGICAL]) begin
			a16 = vxa_pkg::vxa_base_of(target[15:8]) + {10'h000, target[5:0]};
		end else if (ctrl[`VXA_CTRL_MAPPED]) begin
			a16     = {`VXA_REGION_TOP, target[13:0]};
			addr_ok = (target[23:14] == `VXA_MAP_PAGE);
		end
		if (i_read) begin
			case (i_addr)
				`VXA_H_ADDR:   next_o_rdata = {8'h00, target};
				`VXA_H_WDATA:  next_o_rdata = {16'h0000, wdata};
				`VXA_H_CTRL:   next_o_rdata = {27'h0, ctrl};
				`VXA_H_STATUS: next_o_rdata = {28'h0000000, status};
				`VXA_H_RDATA:  next_o_rdata = {16'h0000, rdata};
				default:       next_o_rdata = 32'h0000_0000;
			endcase
		end
		if (i_write && state == vxa_pkg::VXA_IDLE) begin
			case (i_addr)
				`VXA_H_ADDR:  next_target = i_wdata[23:0];
				`VXA_H_WDATA: next_wdata  = i_wdata[15:0];
				`VXA_H_CTRL: begin
					next_ctrl = i_wdata[4:0];
					go        = i_wdata[`VXA_CTRL_GO];
				end
				default: next_target = target;
			endcase
		end
		case (state)
			vxa_pkg::VXA_IDLE: begin
				if (go) begin
					next_status = 4'h0;
					next_state  = vxa_pkg::VXA_ISSUE;
					next_status[`VXA_STAT_BUSY] = 1'b1;
				end
			end
			vxa_pkg::VXA_ISSUE: begin
				if (!addr_ok) begin
					next_status[`VXA_STAT_BUSY]    = 1'b0;
					next_status[`VXA_STAT_DONE]    = 1'b1;
					next_status[`VXA_STAT_BADADDR] = 1'b1;
					next_state = vxa_pkg::VXA_IDLE;
				end else begin
					next_addr      = a16;
					next_bus_wdata = wdata;
					next_write     = ctrl[`VXA_CTRL_WRITE];
					next_read      = ~ctrl[`VXA_CTRL_WRITE];
					next_byte      = ctrl[`VXA_CTRL_BYTE];
					next_wait_cnt  = `VXA_ACK_TIMEOUT;
					next_state     = vxa_pkg::VXA_WAIT;
				end
			end
			vxa_pkg::VXA_WAIT: begin
				if (bus.ack) begin
					if (!ctrl[`VXA_CTRL_WRITE]) begin
						next_rdata = bus.rdata;
					end
					next_status[`VXA_STAT_BUSY] = 1'b0;
					next_status[`VXA_STAT_DONE] = 1'b1;
					next_state = vxa_pkg::VXA_IDLE;
				end else if (wait_cnt == 4'h1) begin
					next_status[`VXA_STAT_BUSY]   = 1'b0;
					next_status[`VXA_STAT_DONE]   = 1'b1;
					next_status[`VXA_STAT_NORESP] = 1'b1;
					next_state = vxa_pkg::VXA_IDLE;
				end else begin
					next_wait_cnt = wait_cnt - 4'h1;
				end
			end
			default: next_state = vxa_pkg::VXA_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state       <= vxa_pkg::VXA_IDLE;
			target      <= 24'h000000;
			wdata       <= 16'h0000;
			ctrl        <= 5'h00;
			status      <= 4'h0;
			rdata       <= 16'h0000;
			wait_cnt    <= 4'h0;
			o_rdata     <= 32'h0000_0000;
			bus.addr    <= 16'h0000;
			bus.wdata   <= 16'h0000;
			bus.write   <= 1'b0;
			bus.read    <= 1'b0;
			bus.byte_sz <= 1'b0;
		end else begin
			state       <= next_state;
			target      <= next_target;
			wdata       <= next_wdata;
			ctrl        <= next_ctrl;
			status      <= next_status;
			rdata       <= next_rdata;
			wait_cnt    <= next_wait_cnt;
			o_rdata     <= next_o_rdata;
			bus.addr    <= next_addr;
			bus.wdata   <= next_bus_wdata;
			bus.write   <= next_write;
			bus.read    <= next_read;
			bus.byte_sz <= next_byte;
		end
	end

endmodule

// file: logic/vxa_pkg.sv
`include "vxa_defs.svh"

package vxa_pkg;

	typedef enum logic [1:0] {
		VXA_IDLE,
		VXA_ISSUE,
		VXA_WAIT
	} vxa_host_state_t;

	// bare-bus base of a logical address setting
	function automatic logic [15:0] vxa_base_of(input logic [7:0] la);
		vxa_base_of = `VXA_REGION_START + {2'b00, la, 6'h00};
	endfunction

	// byte write lands in one lane: even address high byte, odd low byte
	function automatic logic [15:0] vxa_lane_merge(input logic [15:0] old,
	                                                input logic [15:0] wd,
	                                                input logic        byte_sz,
	                                                input logic        odd);
		if (!byte_sz) begin
			vxa_lane_merge = wd;
		end else if (odd) begin
			vxa_lane_merge = {old[15:8], wd[7:0]};
		end else begin
			vxa_lane_merge = {wd[7:0], old[7:0]};
		end
	endfunction

	// byte read returns the addressed lane in the low bits
	function automatic logic [15:0] vxa_lane_pick(input logic [15:0] r,
	                                               input logic        byte_sz,
	                                               input logic        odd);
		if (!byte_sz) begin
			vxa_lane_pick = r;
		end else if (odd) begin
			vxa_lane_pick = {8'h00, r[7:0]};
		end else begin
			vxa_lane_pick = {8'h00, r[15:8]};
		end
	endfunction

endpackage

// file: sim/vxa_props.sv
`timescale 1ns/1ps

module vxa_props (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_write,
	input  wire logic        i_read,
	input  wire logic        i_byte_sz,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_ack,
	input  wire logic [7:0]  i_setting
);
	logic hit;
	logic used;

	assign hit  = (i_addr[15:14] == 2'b11) && (i_addr[13:6] == i_setting);
	assign used = i_addr[5:1] inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h06};

	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////
	hit_ack_a: assert property ((i_write || i_read) && hit |=> i_ack)
		else $error("no ack after block hit");
	region_miss_a: assert property (
		(i_write || i_read) && i_addr[15:14] != 2'b11 |=> !i_ack)
		else $error("ack outside register region");
	block_miss_a: assert property (
		(i_write || i_read) && i_addr[13:6] != i_setting |=> !i_ack)
		else $error("ack outside own block");
	ack_cause_a: assert property (i_ack |-> $past((i_write || i_read) && hit))
		else $error("ack without strobe");
	unused_zero_a: assert property (
		i_read && hit && !used |=> i_ack && i_rdata == 16'h0000)
		else $error("unused offset read not zero");
	idle_zero_a: assert property (!i_ack |-> i_rdata == 16'h0000)
		else $error("read data outside ack cycle");
	write_quiet_a: assert property (i_write && hit |=> i_ack && i_rdata == 16'h0000)
		else $error("write returned data");
	byte_lane_a: assert property (i_read && hit && i_byte_sz |=> i_rdata[15:8] == 8'h00)
		else $error("byte read high lane not zero");
	reset_setting_a: assert property ($fell(i_rst) |-> i_setting == 8'h18)
		else $error("setting not default after reset");

	cover property (i_write && hit);
	cover property (i_read && hit && i_byte_sz);
	cover property ((i_write || i_read) && !hit);
	cover property (i_write && hit && !used && i_wdata != 16'h0000);
endmodule

// file: sim/vxi_a16_register_decode_tb.sv
`timescale 1ns/1ps

module vxi_a16_register_decode_tb;
	localparam logic [5:0] OFFS [6] = '{6'h00, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h06};

	logic        i_ref_clk;
	logic        i_rst;
	logic [3:0]  h_addr;
	logic [31:0] h_wdata;
	logic        h_write;
	logic        h_read;
	logic [31:0] h_rdata;
	logic        la_load;
	logic [7:0]  la_value;
	logic [15:0] rv [5];
	logic [7:0]  la;
	logic [15:0] ctl;
	logic [15:0] cmd;
	logic [15:0] prm;
	logic [31:0] st;
	logic [31:0] rd;
	logic        ctl_stb;
	logic        cmd_stb;
	logic        prm_stb;
	logic        qry_tk;
	logic        dat_tk;
	int          pulses [5];
	int          mismatches;
	int          checks_done;

	vxa_bus_if u_vxa_bus_if ();

	vxa_device u_vxa_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(u_vxa_bus_if.device),
		.i_la_load(la_load), .i_la_value(la_value), .i_id_value(rv[0]), .i_type_value(rv[1]),
		.i_status_value(rv[2]), .i_query_value(rv[3]), .i_data_value(rv[4]),
		.o_logical_address_setting(la), .o_control(ctl), .o_command(cmd), .o_parameter(prm),
		.o_control_strobe(ctl_stb), .o_command_strobe(cmd_stb), .o_parameter_strobe(prm_stb),
		.o_query_taken(qry_tk), .o_data_taken(dat_tk));

	vxa_host u_vxa_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(u_vxa_bus_if.host),
		.i_addr(h_addr), .i_wdata(h_wdata), .i_write(h_write), .i_read(h_read),
		.o_rdata(h_rdata));

	vxa_props u_vxa_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(u_vxa_bus_if.addr),
		.i_wdata(u_vxa_bus_if.wdata), .i_write(u_vxa_bus_if.write),
		.i_read(u_vxa_bus_if.read), .i_byte_sz(u_vxa_bus_if.byte_sz),
		.i_rdata(u_vxa_bus_if.rdata), .i_ack(u_vxa_bus_if.ack), .i_setting(la));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic hw(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		h_addr  <= a;
		h_wdata <= d;
		h_write <= 1'b1;
		@(posedge i_ref_clk);
		h_write <= 1'b0;
	endtask

	task automatic hr(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		h_addr <= a;
		h_read <= 1'b1;
		@(posedge i_ref_clk);
		h_read <= 1'b0;
		#1;
		d = h_rdata;
	endtask

	// one bus transfer through the host port, status left in st
	task automatic op(input logic [23:0] t, input logic [7:0] c, input logic [15:0] d);
		hw(4'h0, {8'h00, t});
		hw(4'h1, {16'h0000, d});
		hw(4'h2, {24'h000000, c});
		st = 32'h00000000;
		for (int n = 0; n < 40 && !(st[1] && !st[0]); n++) begin
			hr(4'h3, st);
		end
		if (!(st[1] && !st[0])) begin
			mismatches++;
			$display("CHECK FAILED t=%0t host transfer never finished", $time);
		end
		hr(4'h4, rd);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	// pulses seen on the user side strobes
	always @(posedge i_ref_clk) begin
		if (!i_rst) begin
			pulses[0] <= pulses[0] + int'(ctl_stb);
			pulses[1] <= pulses[1] + int'(cmd_stb);
			pulses[2] <= pulses[2] + int'(prm_stb);
			pulses[3] <= pulses[3] + int'(qry_tk);
			pulses[4] <= pulses[4] + int'(dat_tk);
		end
	end

	initial begin
		repeat (6000) @(posedge i_ref_clk);
		mismatches++;
		summarize();
	end

	initial begin
		i_rst = 1'b1;
		h_addr = 4'h0;
		h_wdata = 32'h00000000;
		h_write = 1'b0;
		h_read = 1'b0;
		la_load = 1'b0;
		la_value = 8'h00;
		rv = '{16'hF0A1, 16'h5A5A, 16'h3C96, 16'h8E17, 16'h24BD};
		mismatches = 0;
		checks_done = 0;
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		chk({8'h00, la}, 16'h0018);
		op(24'h00C604, 8'h03, 16'hA5C3);
		chk(ctl, 16'hA5C3);
		op(24'h00C608, 8'h03, 16'h0004);
		chk(cmd, 16'h0004);
		op(24'h00C60A, 8'h03, 16'h1234);
		chk(prm, 16'h1234);
		chk({12'h000, st[3:0]}, 16'h0002);
		op(24'h00C606, 8'h03, 16'hFFFF);
		op(24'h00C60C, 8'h03, 16'hFFFF);
		chk(ctl, 16'hA5C3);
		chk(cmd, 16'h0004);
		chk(prm, 16'h1234);
		$display("test word writes done");
		for (int i = 0; i < 6; i++) begin
			op({8'h00, 8'hC6, 2'b00, OFFS[i]}, 8'h01, 16'h0000);
			chk(rd[15:0], (i < 5) ? rv[i] : 16'h0000);
			chk({12'h000, st[3:0]}, 16'h0002);
		end
		$display("test word reads done");
		op(24'h00C609, 8'h07, 16'h0077);
		op(24'h00C608, 8'h07, 16'h0012);
		chk(cmd, 16'h1277);
		op(24'h00C605, 8'h05, 16'h0000);
		chk(rd[15:0], {8'h00, rv[2][7:0]});
		op(24'h00C604, 8'h05, 16'h0000);
		chk(rd[15:0], {8'h00, rv[2][15:8]});
		$display("test byte access done");
		op(24'h1FC60A, 8'h13, 16'h00AB);
		chk(prm, 16'h00AB);
		op(24'h100000, 8'h13, 16'h0055);
		chk({12'h000, st[3:0]}, 16'h000A);
		op(24'h00180A, 8'h0B, 16'h0CDE);
		chk(prm, 16'h0CDE);
		op(24'h00C648, 8'h03, 16'h0055);
		chk({12'h000, st[3:0]}, 16'h0006);
		op(24'h008608, 8'h03, 16'h0055);
		chk({12'h000, st[3:0]}, 16'h0006);
		chk(cmd, 16'h1277);
		$display("test decode misses done");
		@(posedge i_ref_clk);
		la_value <= 8'h19;
		la_load <= 1'b1;
		@(posedge i_ref_clk);
		la_load <= 1'b0;
		op(24'h00C648, 8'h03, 16'h0055);
		chk(cmd, 16'h0055);
		chk({8'h00, la}, 16'h0019);
		$display("test moved block done");
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		chk({8'h00, la}, 16'h0018);
		op(24'h00C608, 8'h01, 16'h0000);
		chk(rd[15:0], rv[3]);
		$display("test reset in run done");
		chk(16'(pulses[0]), 16'h0001);
		chk(16'(pulses[1]), 16'h0004);
		chk(16'(pulses[2]), 16'h0003);
		chk(16'(pulses[3]), 16'h0002);
		chk(16'(pulses[4]), 16'h0001);
		$display("test strobe counts done");
		summarize();
	end
endmodule
